// File: core/alarm_gage_pkg.sv
// Shared constants, codes and carrier types for the channel alarm and gage calibration block
package alarm_gage_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    localparam int DATA_W = 32;
    localparam int FRAC_W = 16;
    localparam int SEL_W = 2;
    localparam int TYPE_W = 8;

    typedef logic [CH_W-1:0] chan_t;
    typedef logic signed [DATA_W-1:0] value_t;
    typedef logic [TYPE_W-1:0] sensor_t;
    typedef logic [SEL_W-1:0] std_sel_t;
    typedef logic [NUM_CH-1:0] chan_mask_t;

    // ------------------------------------------------------------------
    // Sensor type codes and reset values
    // ------------------------------------------------------------------
    localparam sensor_t TYPE_VOLT_5V = 8'h00;
    localparam sensor_t TYPE_MV_500 = 8'h01;
    localparam sensor_t TYPE_OHM_400 = 8'h02;
    localparam sensor_t TYPE_GAGE = 8'h10;
    localparam sensor_t RESET_SENSOR_TYPE = TYPE_VOLT_5V;
    localparam chan_mask_t RESET_ARM = 16'h0000;
    localparam value_t UNITY_GAIN = 32'h0001_0000;
    localparam value_t ZERO_VALUE = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Reference standard selectors
    // ------------------------------------------------------------------
    localparam std_sel_t STD_VOLT_5V = 2'h0;
    localparam std_sel_t STD_MV_500 = 2'h1;
    localparam std_sel_t STD_OHM_380 = 2'h2;

    // ------------------------------------------------------------------
    // Commands and carriers
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_SENSOR_TYPE,
        CMD_THRESHOLDS,
        CMD_ALARM_ARM,
        CMD_ALARM_READ,
        CMD_GAGE_ZERO,
        CMD_GAGE_SPAN,
        CMD_GAGE_TARE,
        CMD_PARAMS_READ,
        CMD_PARAMS_RESTORE,
        CMD_REF_CAL,
        CMD_BOARD_RESET
    } cmd_op_e;

    typedef struct packed {
        value_t zero;
        value_t gain;
        value_t tare;
    } gage_param_s;

    typedef struct packed {
        cmd_op_e op;
        chan_t ch;
        logic flag;
        value_t arg_a;
        value_t arg_b;
        gage_param_s params;
    } cmd_s;

    typedef struct packed {
        chan_t ch;
        value_t raw;
    } sample_s;

    typedef struct packed {
        logic valid;
        chan_t ch;
        value_t value;
    } result_s;

    typedef struct packed {
        logic valid;
        logic done;
        value_t data;
        gage_param_s params;
        chan_mask_t alarm_flags;
        logic any_alarm;
    } rsp_s;

    typedef struct packed {
        logic valid;
        std_sel_t sel;
        sensor_t range;
        value_t value;
    } nvm_s;

    typedef struct packed {
        value_t raw_last;
        value_t upper;
        value_t lower;
        gage_param_s gp;
    } chan_mem_s;

    localparam int MEM_W = $bits(chan_mem_s);

endpackage : alarm_gage_pkg

// File: core/chan_param_mem.sv
// Per-channel parameter memory with registered read data
`timescale 1ns/10ps
module chan_param_mem
    import alarm_gage_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_rd_en,
    input wire alarm_gage_pkg::chan_t i_rd_addr,
    output alarm_gage_pkg::chan_mem_s o_rd_data,
    input wire logic i_wr_en,
    input wire alarm_gage_pkg::chan_t i_wr_addr,
    input wire alarm_gage_pkg::chan_mem_s i_wr_data
);
    chan_mem_s mem [NUM_CH];
    chan_mem_s next_rd_data;

    always_comb
    begin
        next_rd_data = o_rd_data;
        if (i_rd_en)
        begin
            next_rd_data = mem[i_rd_addr];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            o_rd_data <= '0;
        end
        else
        begin
            o_rd_data <= next_rd_data;
        end
        if (i_wr_en)
        begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

endmodule : chan_param_mem

// File: core/channel_alarm_gage.sv
// Command interpreter for channel alarms, gage calibration and reference calibration
`timescale 1ns/10ps
module channel_alarm_gage
    import alarm_gage_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_cmd_valid,
    input wire alarm_gage_pkg::cmd_s i_cmd,
    output logic o_cmd_ready,
    input wire logic i_sample_valid,
    input wire alarm_gage_pkg::sample_s i_sample,
    output logic o_sample_ready,
    output alarm_gage_pkg::result_s o_result,
    output alarm_gage_pkg::rsp_s o_rsp,
    output alarm_gage_pkg::nvm_s o_nvm_wr,
    output alarm_gage_pkg::chan_mask_t o_arm_flags,
    output logic o_alarm_status
);
    import alarm_gage_pkg::*;

    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------
    function automatic value_t apply_gain(input value_t v, input value_t g);
        logic signed [2*DATA_W-1:0] prod;
        prod = v * g;
        return prod[FRAC_W +: DATA_W];
    endfunction : apply_gain

    // Guarded so that a zero measurement cannot divide by zero
    function automatic value_t scale_factor(input value_t target, input value_t meas);
        logic signed [2*DATA_W-1:0] num;
        logic signed [2*DATA_W-1:0] quo;
        num = {{(DATA_W-FRAC_W){target[DATA_W-1]}}, target, {FRAC_W{1'b0}}};
        quo = (meas == ZERO_VALUE) ? {{DATA_W{1'b0}}, UNITY_GAIN}
                                   : num / {{DATA_W{meas[DATA_W-1]}}, meas};
        return quo[DATA_W-1:0];
    endfunction : scale_factor

    function automatic sensor_t std_range(input std_sel_t sel);
        case (sel)
            STD_VOLT_5V: return TYPE_VOLT_5V;
            STD_MV_500: return TYPE_MV_500;
            default: return TYPE_OHM_400;
        endcase
    endfunction : std_range

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT,
        ST_IDLE,
        ST_EXEC
    } state_e;

    state_e state;
    state_e next_state;
    chan_t init_addr;
    chan_t next_init_addr;
    logic job_is_cmd;
    logic next_job_is_cmd;
    cmd_s job_cmd;
    cmd_s next_job_cmd;
    sample_s job_smp;
    sample_s next_job_smp;
    chan_mask_t arm;
    chan_mask_t next_arm;
    chan_mask_t sounding;
    chan_mask_t next_sounding;
    sensor_t sensor_type [NUM_CH];
    sensor_t next_sensor_type [NUM_CH];
    logic alarm_status;
    logic next_alarm_status;
    result_s next_result;
    rsp_s next_rsp;
    nvm_s next_nvm;

    logic mem_rd_en;
    chan_t mem_rd_addr;
    chan_mem_s mem_rd_data;
    logic mem_wr_en;
    chan_t mem_wr_addr;
    chan_mem_s mem_wr_data;

    chan_param_mem u_mem (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_rd_en(mem_rd_en),
        .i_rd_addr(mem_rd_addr),
        .o_rd_data(mem_rd_data),
        .i_wr_en(mem_wr_en),
        .i_wr_addr(mem_wr_addr),
        .i_wr_data(mem_wr_data)
    );

    // ------------------------------------------------------------------
    // Handshake: commands take priority over samples
    // ------------------------------------------------------------------
    assign o_cmd_ready = (state == ST_IDLE);
    assign o_sample_ready = (state == ST_IDLE) && !i_cmd_valid;
    assign mem_rd_en = (state == ST_IDLE) && (i_cmd_valid || i_sample_valid);
    assign mem_rd_addr = i_cmd_valid ? i_cmd.ch : i_sample.ch;
    assign o_arm_flags = arm;
    assign o_alarm_status = alarm_status;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        chan_mem_s w;
        value_t norm;
        value_t load;
        logic is_gage;
        w = mem_rd_data;
        norm = mem_rd_data.raw_last - mem_rd_data.gp.zero;
        load = ZERO_VALUE;
        is_gage = 1'b0;
        next_state = state;
        next_init_addr = init_addr;
        next_job_is_cmd = job_is_cmd;
        next_job_cmd = job_cmd;
        next_job_smp = job_smp;
        next_arm = arm;
        next_sounding = sounding;
        next_sensor_type = sensor_type;
        next_alarm_status = alarm_status;
        next_result = '0;
        next_rsp = '0;
        next_nvm = '0;
        mem_wr_en = 1'b0;
        mem_wr_addr = job_is_cmd ? job_cmd.ch : job_smp.ch;
        mem_wr_data = w;
        case (state)
            ST_INIT:
            begin
                // Fresh words read as unity gain so uncalibrated gages pass through
                mem_wr_en = 1'b1;
                mem_wr_addr = init_addr;
                mem_wr_data = '0;
                mem_wr_data.gp.gain = UNITY_GAIN;
                next_init_addr = init_addr + 1'b1;
                if (init_addr == chan_t'(NUM_CH - 1))
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (i_cmd_valid)
                begin
                    next_job_is_cmd = 1'b1;
                    next_job_cmd = i_cmd;
                    next_state = ST_EXEC;
                end
                else if (i_sample_valid)
                begin
                    next_job_is_cmd = 1'b0;
                    next_job_smp = i_sample;
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                next_state = ST_IDLE;
                if (!job_is_cmd)
                begin
                    w.raw_last = job_smp.raw;
                    load = job_smp.raw;
                    if (sensor_type[job_smp.ch] == TYPE_GAGE)
                    begin
                        load = apply_gain(job_smp.raw - w.gp.zero, w.gp.gain) - w.gp.tare;
                    end
                    mem_wr_en = 1'b1;
                    mem_wr_data = w;
                    next_result.valid = 1'b1;
                    next_result.ch = job_smp.ch;
                    next_result.value = load;
                    if (arm[job_smp.ch] && (load > w.upper || load < w.lower))
                    begin
                        next_sounding[job_smp.ch] = 1'b1;
                        next_arm[job_smp.ch] = 1'b0;
                        next_alarm_status = 1'b1;
                    end
                end
                else
                begin
                    next_rsp.valid = 1'b1;
                    next_rsp.done = 1'b1;
                    is_gage = (sensor_type[job_cmd.ch] == TYPE_GAGE);
                    case (job_cmd.op)
                        CMD_SENSOR_TYPE:
                        begin
                            next_sensor_type[job_cmd.ch] = job_cmd.arg_a[TYPE_W-1:0];
                            next_arm[job_cmd.ch] = 1'b0;
                            next_sounding[job_cmd.ch] = 1'b0;
                            w.upper = ZERO_VALUE;
                            w.lower = ZERO_VALUE;
                            mem_wr_en = 1'b1;
                            mem_wr_data = w;
                        end
                        CMD_THRESHOLDS:
                        begin
                            w.upper = job_cmd.arg_a;
                            w.lower = job_cmd.arg_b;
                            mem_wr_en = 1'b1;
                            mem_wr_data = w;
                        end
                        CMD_ALARM_ARM:
                        begin
                            next_arm[job_cmd.ch] = job_cmd.flag;
                            next_sounding[job_cmd.ch] = 1'b0;
                        end
                        CMD_ALARM_READ:
                        begin
                            next_rsp.alarm_flags = sounding;
                            next_rsp.any_alarm = |sounding;
                            next_sounding = '0;
                            next_alarm_status = 1'b0;
                        end
                        CMD_GAGE_ZERO:
                        begin
                            if (is_gage)
                            begin
                                w.gp.zero = w.raw_last;
                                mem_wr_en = 1'b1;
                                mem_wr_data = w;
                            end
                        end
                        CMD_GAGE_SPAN:
                        begin
                            if (is_gage)
                            begin
                                w.gp.gain = scale_factor(job_cmd.arg_a, norm);
                                w.gp.tare = ZERO_VALUE;
                                mem_wr_en = 1'b1;
                                mem_wr_data = w;
                            end
                        end
                        CMD_GAGE_TARE:
                        begin
                            if (is_gage)
                            begin
                                w.gp.tare = apply_gain(norm, w.gp.gain);
                                mem_wr_en = 1'b1;
                                mem_wr_data = w;
                            end
                        end
                        CMD_PARAMS_READ:
                        begin
                            if (is_gage)
                            begin
                                next_rsp.params = w.gp;
                            end
                        end
                        CMD_PARAMS_RESTORE:
                        begin
                            if (is_gage)
                            begin
                                w.gp = job_cmd.params;
                                mem_wr_en = 1'b1;
                                mem_wr_data = w;
                            end
                        end
                        CMD_REF_CAL:
                        begin
                            // Selector 3 names no standard and is dropped
                            if (job_cmd.arg_b[SEL_W-1:0] <= STD_OHM_380)
                            begin
                                next_nvm.valid = 1'b1;
                                next_nvm.sel = job_cmd.arg_b[SEL_W-1:0];
                                next_nvm.range = std_range(job_cmd.arg_b[SEL_W-1:0]);
                                next_nvm.value = scale_factor(job_cmd.arg_a, w.raw_last);
                                next_rsp.data = next_nvm.value;
                            end
                        end
                        CMD_BOARD_RESET:
                        begin
                            next_arm = RESET_ARM;
                            next_sounding = '0;
                            next_alarm_status = 1'b0;
                            for (int i = 0; i < NUM_CH; i++)
                            begin
                                next_sensor_type[i] = RESET_SENSOR_TYPE;
                            end
                        end
                        default:
                        begin
                            next_rsp.valid = 1'b1;
                        end
                    endcase
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            state <= ST_INIT;
            init_addr <= '0;
            job_is_cmd <= 1'b0;
            job_cmd <= '0;
            job_smp <= '0;
            arm <= RESET_ARM;
            sounding <= '0;
            alarm_status <= 1'b0;
            o_result <= '0;
            o_rsp <= '0;
            o_nvm_wr <= '0;
            for (int i = 0; i < NUM_CH; i++)
            begin
                sensor_type[i] <= RESET_SENSOR_TYPE;
            end
        end
        else
        begin
            state <= next_state;
            init_addr <= next_init_addr;
            job_is_cmd <= next_job_is_cmd;
            job_cmd <= next_job_cmd;
            job_smp <= next_job_smp;
            arm <= next_arm;
            sounding <= next_sounding;
            alarm_status <= next_alarm_status;
            o_result <= next_result;
            o_rsp <= next_rsp;
            o_nvm_wr <= next_nvm;
            sensor_type <= next_sensor_type;
        end
    end

endmodule : channel_alarm_gage

// File: dv/host_client.sv
// Host client model that issues commands to the alarm and gage block
`timescale 1ns/10ps
module host_client
    import alarm_gage_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_ready,
    output logic o_valid,
    output alarm_gage_pkg::cmd_s o_cmd
);
    initial
    begin
        o_valid = 1'b0;
        o_cmd = '0;
    end

    // Holds the request until taken or 64 cycles pass; never reads the answer back
    task automatic send(input cmd_s c);
        int n;
        @(posedge i_ref_clk);
        o_valid <= 1'b1;
        o_cmd <= c;
        n = 0;
        @(negedge i_ref_clk);
        while (i_ready !== 1'b1 && n < 64)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        @(posedge i_ref_clk);
        o_valid <= 1'b0;
        // Released payload is scrambled so a stale word cannot pass as valid
        o_cmd <= cmd_s'(~c);
    endtask : send
endmodule : host_client

// File: dv/channel_alarm_gage_sva.sv
// Port-level checks for the alarm and gage command block
`timescale 1ns/10ps
module channel_alarm_gage_sva
    import alarm_gage_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_cmd_valid,
    input wire alarm_gage_pkg::cmd_s i_cmd,
    input wire logic o_cmd_ready,
    input wire logic i_sample_valid,
    input wire alarm_gage_pkg::sample_s i_sample,
    input wire logic o_sample_ready,
    input wire alarm_gage_pkg::result_s o_result,
    input wire alarm_gage_pkg::rsp_s o_rsp,
    input wire alarm_gage_pkg::nvm_s o_nvm_wr,
    input wire alarm_gage_pkg::chan_mask_t o_arm_flags,
    input wire logic o_alarm_status
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);
    wire logic take = i_cmd_valid && o_cmd_ready;
    wire logic arm_on = take && i_cmd.op == CMD_ALARM_ARM && i_cmd.flag;
    wire logic cal_go = take && i_cmd.op == CMD_REF_CAL;
    // ----
    // Command steps: taken, busy for one cycle, answered
    // ----
    sequence taken(cmd_op_e op);
        take && i_cmd.op == op;
    endsequence
    sequence answered;
        !o_cmd_ready ##1 (o_rsp.valid && o_cmd_ready);
    endsequence
    property arm_p;
        chan_t c;
        logic f;
        (taken(CMD_ALARM_ARM), c = i_cmd.ch, f = i_cmd.flag) |=> answered ##0 o_arm_flags[c] == f;
    endproperty
    property type_p;
        chan_t c;
        (taken(CMD_SENSOR_TYPE), c = i_cmd.ch) |=> answered ##0 !o_arm_flags[c];
    endproperty
    property cal_p;
        std_sel_t s;
        (taken(CMD_REF_CAL), s = i_cmd.arg_b[1:0]) |=> answered ##0 ((s == 2'h3) != o_nvm_wr.valid)
            && (s == 2'h3 || (o_nvm_wr.sel == s && o_nvm_wr.range == sensor_t'(s)));
    endproperty
    property res_p;
        chan_t c;
        (i_sample_valid && o_sample_ready, c = i_sample.ch) |=> ##1 o_result.valid && o_result.ch == c;
    endproperty
    arm_cmd_a: assert property (arm_p) else $error("arm flag not as commanded");
    type_disarm_a: assert property (type_p) else $error("typed channel still armed");
    ref_cal_a: assert property (cal_p) else $error("reference write wrong");
    result_ch_a: assert property (res_p) else $error("result missing");
    arm_source_a: assert property (
        |(o_arm_flags & ~$past(o_arm_flags)) |-> $past(arm_on, 2)) else $error("arm rose unbidden");
    sound_clear_a: assert property (
        $rose(o_alarm_status) |-> o_result.valid && !o_arm_flags[o_result.ch]
        && $past(o_arm_flags) != o_arm_flags) else $error("sounding without disarm");
    read_ack_a: assert property (taken(CMD_ALARM_READ) |=> answered ##0
        o_rsp.any_alarm == $past(o_alarm_status) && o_rsp.any_alarm == |o_rsp.alarm_flags
        && !o_alarm_status) else $error("alarm read wrong");
    nvm_source_a: assert property (
        o_nvm_wr.valid |-> $past(cal_go, 2)) else $error("stray reference write");
    board_clear_a: assert property (taken(CMD_BOARD_RESET) |=> answered ##0
        o_arm_flags == RESET_ARM && !o_alarm_status) else $error("board reset kept alarms");
    reset_idle_a: assert property ($rose(i_resetn) |->
        (o_arm_flags == RESET_ARM && !o_cmd_ready)[*8]) else $error("armed after reset");
endmodule : channel_alarm_gage_sva

bind channel_alarm_gage channel_alarm_gage_sva i_sva (.i_ref_clk, .i_resetn, .i_cmd_valid, .i_cmd,
    .o_cmd_ready, .i_sample_valid, .i_sample, .o_sample_ready, .o_result, .o_rsp, .o_nvm_wr,
    .o_arm_flags, .o_alarm_status);

// File: dv/testbench.sv
// Self-checking bench for the alarm and gage command block
`timescale 1ns/10ps
module testbench;
    import alarm_gage_pkg::*;
    typedef struct packed {
        cmd_op_e op;
        chan_t ch;
        logic fl;
        value_t a;
        chan_mask_t arm;
    } row_s;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_cmd_valid;
    cmd_s i_cmd;
    logic o_cmd_ready;
    logic i_sample_valid = 1'b0;
    sample_s i_sample = '0;
    logic o_sample_ready;
    result_s o_result;
    rsp_s o_rsp;
    nvm_s o_nvm_wr;
    chan_mask_t o_arm_flags;
    logic o_alarm_status;
    int errors = 0;
    int comparisons = 0;
    int n_rsp = 0;
    int n_nvm = 0;
    int k0;
    rsp_s rsp_q;
    result_s res_q;
    nvm_s nvm_q;
    row_s rows[6];

    always #25 i_ref_clk = ~i_ref_clk;

    host_client i_host_client (.i_ref_clk(i_ref_clk), .i_ready(o_cmd_ready),
        .o_valid(i_cmd_valid), .o_cmd(i_cmd));
    channel_alarm_gage i_channel_alarm_gage (.i_ref_clk, .i_resetn, .i_cmd_valid, .i_cmd,
        .o_cmd_ready, .i_sample_valid, .i_sample, .o_sample_ready, .o_result, .o_rsp,
        .o_nvm_wr, .o_arm_flags, .o_alarm_status);

    // Pulses are caught at the falling edge, clear of the launching edge
    always @(negedge i_ref_clk)
    begin
        if (o_rsp.valid === 1'b1) rsp_q = o_rsp;
        if (o_rsp.valid === 1'b1) n_rsp++;
        if (o_result.valid === 1'b1) res_q = o_result;
        if (o_nvm_wr.valid === 1'b1) nvm_q = o_nvm_wr;
        if (o_nvm_wr.valid === 1'b1) n_nvm++;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cmd(input cmd_op_e op, input chan_t ch, input logic fl, input value_t a,
        input value_t b, input gage_param_s p = '0);
        int k;
        k = n_rsp;
        i_host_client.send('{op, ch, fl, a, b, p});
        for (int i = 0; i < 6 && n_rsp == k; i++) @(posedge i_ref_clk);
        chk("answer", 32'h1, 32'(n_rsp - k));
    endtask : cmd

    task automatic smp(input chan_t ch, input value_t raw);
        int n;
        @(posedge i_ref_clk);
        i_sample_valid <= 1'b1;
        i_sample <= '{ch, raw};
        n = 0;
        @(negedge i_ref_clk);
        while (o_sample_ready !== 1'b1 && n < 64)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        @(posedge i_ref_clk);
        i_sample_valid <= 1'b0;
        i_sample <= sample_s'(~{ch, raw});
        repeat (3) @(posedge i_ref_clk);
    endtask : smp

    task automatic final_report();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // Whole sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        errors++;
        final_report();
    end

    initial
    begin
        rows = '{'{CMD_ALARM_ARM, 4'h3, 1'b1, 32'h0, 16'h0008},
            '{CMD_ALARM_ARM, 4'hf, 1'b1, 32'h0, 16'h8008},
            '{CMD_ALARM_ARM, 4'h3, 1'b0, 32'h0, 16'h8000},
            '{CMD_ALARM_ARM, 4'h0, 1'b1, 32'h0, 16'h8001},
            '{CMD_SENSOR_TYPE, 4'hf, 1'b0, 32'h10, 16'h0001},
            '{CMD_BOARD_RESET, 4'h0, 1'b0, 32'h0, 16'h0000}};
        repeat (5) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        foreach (rows[i])
        begin
            cmd(rows[i].op, rows[i].ch, rows[i].fl, rows[i].a, 32'h0);
            chk("arm", {16'h0, rows[i].arm}, {16'h0, o_arm_flags});
        end
        // Limits first, then arm; compare is strict at the limit
        cmd(CMD_THRESHOLDS, 4'h5, 1'b0, 32'h64, 32'hffffff9c);
        cmd(CMD_ALARM_ARM, 4'h5, 1'b1, 32'h0, 32'h0);
        smp(4'h5, 32'h64);
        chk("arm at limit", 32'h20, {16'h0, o_arm_flags});
        smp(4'h5, 32'hffffff9b);
        chk("arm", 32'h0, {16'h0, o_arm_flags});
        chk("status", 32'h1, {31'h0, o_alarm_status});
        cmd(CMD_ALARM_READ, 4'h0, 1'b0, 32'h0, 32'h0);
        chk("flags", 32'h20, {16'h0, rsp_q.alarm_flags});
        chk("any", 32'h1, {31'h0, rsp_q.any_alarm});
        smp(4'h5, 32'hffffff9b);
        chk("status", 32'h0, {31'h0, o_alarm_status});
        cmd(CMD_ALARM_READ, 4'h0, 1'b0, 32'h0, 32'h0);
        chk("any", 32'h0, {31'h0, rsp_q.any_alarm});
        // Gage: zero, span, tare, read back, restore
        cmd(CMD_SENSOR_TYPE, 4'h2, 1'b0, {24'h0, TYPE_GAGE}, 32'h0);
        smp(4'h2, 32'h3e8);
        cmd(CMD_GAGE_ZERO, 4'h2, 1'b0, 32'h0, 32'h0);
        smp(4'h2, 32'h4e8);
        cmd(CMD_GAGE_SPAN, 4'h2, 1'b0, 32'h200, 32'h0);
        smp(4'h2, 32'h4e8);
        chk("span", 32'h200, res_q.value);
        cmd(CMD_GAGE_TARE, 4'h2, 1'b0, 32'h0, 32'h0);
        smp(4'h2, 32'h468);
        chk("tare", 32'hffffff00, res_q.value);
        cmd(CMD_PARAMS_READ, 4'h2, 1'b0, 32'h0, 32'h0);
        chk("zero", 32'h3e8, rsp_q.params.zero);
        chk("gain", 32'h20000, rsp_q.params.gain);
        chk("tare", 32'h200, rsp_q.params.tare);
        cmd(CMD_PARAMS_RESTORE, 4'h2, 1'b0, 32'h0, 32'h0,
            '{ZERO_VALUE, UNITY_GAIN, ZERO_VALUE});
        smp(4'h2, 32'h28);
        chk("restored", 32'h28, res_q.value);
        cmd(CMD_GAGE_ZERO, 4'h7, 1'b0, 32'h0, 32'h0);
        smp(4'h7, 32'h1e);
        chk("plain", 32'h1e, res_q.value);
        cmd(CMD_PARAMS_READ, 4'h7, 1'b0, 32'h0, 32'h0);
        chk("gain", 32'h0, rsp_q.params.gain);
        // Standards in order, each after matching type and a live reading
        for (int s = 0; s < 4; s++)
        begin
            cmd(CMD_SENSOR_TYPE, 4'h0, 1'b0, 32'(s), 32'h0);
            smp(4'h0, 32'h4);
            k0 = n_nvm;
            cmd(CMD_REF_CAL, 4'h0, 1'b0, 32'h8, 32'(s));
            chk("writes", (s < 3) ? 32'h1 : 32'h0, 32'(n_nvm - k0));
            chk("range", 32'((s < 3) ? s : 2), {24'h0, nvm_q.range});
            chk("value", 32'h20000, nvm_q.value);
            cmd(CMD_BOARD_RESET, 4'h0, 1'b0, 32'h0, 32'h0);
        end
        cmd(CMD_ALARM_ARM, 4'h1, 1'b1, 32'h0, 32'h0);
        i_resetn <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(negedge i_ref_clk);
        chk("arm", 32'h0, {16'h0, o_arm_flags});
        final_report();
    end
endmodule : testbench
